// ==== logic/sws_map.svh ====
// Register offsets, field positions and reset values of the stall block.
`ifndef SWS_MAP_SVH
`define SWS_MAP_SVH

// ==========================================================================
// Register byte offsets
`define SWS_OFF_CS0_CTRL     8'h00
`define SWS_OFF_CS123_CTRL   8'h04
`define SWS_OFF_STATUS       8'h08

// ==========================================================================
// Control word fields
`define SWS_BIT_STALL_EN     2
`define SWS_BIT_STALL_SAMPLE 3
`define SWS_BIT_STALL_MODE   16
`define SWS_RD_LOW_LSB       4
`define SWS_WR_LOW_LSB       8
`define SWS_LOW_WIDTH        4

// ==========================================================================
// Reset values
`define SWS_CTRL_RESET       32'h0000_0000
`define SWS_PIN_IDLE         1'b1
`define SWS_LOW_MIN          4'h1

`endif

// ==== logic/sws_pkg.sv ====
// Types shared by the stall block.
`default_nettype none
package sws_pkg;

  // ========================================================================
  // Access sequencer states
  typedef enum logic [1:0] {
    SWS_IDLE   = 2'b00,
    SWS_STROBE = 2'b01,
    SWS_HOLD   = 2'b10,
    SWS_END    = 2'b11
  } sws_state_e;

endpackage : sws_pkg
`default_nettype wire

// ==== logic/sws_wait_sync.sv ====
// Three-stage synchroniser with agreement filter for the stall pin.
`timescale 1ns/10ps
`default_nettype none
`include "sws_map.svh"

module sws_wait_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstSync_n,
  input  wire logic clkEn,
  // Pin and filtered level
  input  wire logic pinIn,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ========================================================================
  // Sampling chain and filter
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stage1 <= `SWS_PIN_IDLE;
      stage2 <= `SWS_PIN_IDLE;
      stage3 <= `SWS_PIN_IDLE;
      level  <= `SWS_PIN_IDLE;
    end else if (clkEn) begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

endmodule : sws_wait_sync
`default_nettype wire

// ==== logic/sws_top.sv ====
// Static-memory access sequencer with stall-line stretching.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "sws_map.svh"

module sws_top (
  // Clock, reset and enable
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // Wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  // Access request
  input  wire logic        accReq,
  input  wire logic        accWrite,
  input  wire logic [1:0]  accCs,
  output logic             accBusy,
  output logic             accDone,
  // Memory pins
  input  wire logic        stallPin_n,
  output logic [3:0]       chipSelectLine_n,
  output logic             readStrobe_n,
  output logic             writeStrobe_n
);

  logic [1:0]         rstPipe;
  logic               rstSync_n;
  logic [31:0]        cs0Ctrl;
  logic [31:0]        cs123Ctrl;
  logic [31:0]        selCtrl;
  logic [3:0]         lowCnt;
  logic               curWrite;
  logic               pinLevel;
  logic               pinPrev;
  logic               stallSeen;
  logic               pinRise;
  logic               waitOn;
  logic               edgeMode;
  logic               wbReq;
  logic               wbWrite;
  sws_pkg::sws_state_e state;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] din,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  function automatic logic [3:0] lowCount(input logic [31:0] ctrl,
                                          input logic        wr);
    logic [3:0] raw;
    raw = wr ? ctrl[`SWS_WR_LOW_LSB +: `SWS_LOW_WIDTH]
             : ctrl[`SWS_RD_LOW_LSB +: `SWS_LOW_WIDTH];
    return (raw == 4'h0) ? `SWS_LOW_MIN : raw;
  endfunction : lowCount

  // ==========================================================================
  // Reset release
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe[1];

  // ==========================================================================
  // Stall pin conditioning
  sws_wait_sync uSync (
    .core_clk  (core_clk),
    .rstSync_n (rstSync_n),
    .clkEn     (clkEn),
    .pinIn     (stallPin_n),
    .level     (pinLevel)
  );

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinPrev <= `SWS_PIN_IDLE;
    end else if (clkEn) begin
      pinPrev <= pinLevel;
    end
  end

  assign stallSeen = !pinLevel;
  assign pinRise   = pinLevel && !pinPrev;
  assign waitOn    = selCtrl[`SWS_BIT_STALL_EN]
                  && selCtrl[`SWS_BIT_STALL_SAMPLE];
  assign edgeMode  = !selCtrl[`SWS_BIT_STALL_MODE];

  // ==========================================================================
  // Wishbone slave
  assign wbReq   = wbCyc && wbStb;
  assign wbWrite = wbReq && wbWe && wbAck;

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      wbAck  <= 1'b0;
      wbDatO <= 32'h0000_0000;
    end else if (clkEn) begin
      wbAck <= wbReq && !wbAck;
      if (wbReq && !wbAck) begin
        case (wbAdr)
          `SWS_OFF_CS0_CTRL:   wbDatO <= cs0Ctrl;
          `SWS_OFF_CS123_CTRL: wbDatO <= cs123Ctrl;
          `SWS_OFF_STATUS:     wbDatO <= {28'h0000000, state, stallSeen,
                                          accBusy};
          default:             wbDatO <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cs0Ctrl   <= `SWS_CTRL_RESET;
      cs123Ctrl <= `SWS_CTRL_RESET;
    end else if (clkEn && wbWrite) begin
      if (wbAdr == `SWS_OFF_CS0_CTRL) begin
        cs0Ctrl <= mergeBytes(cs0Ctrl, wbDatI, wbSel);
      end
      if (wbAdr == `SWS_OFF_CS123_CTRL) begin
        cs123Ctrl <= mergeBytes(cs123Ctrl, wbDatI, wbSel);
      end
    end
  end

  // ==========================================================================
  // Access sequencer
  always_ff @(posedge core_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state            <= sws_pkg::SWS_IDLE;
      selCtrl          <= `SWS_CTRL_RESET;
      lowCnt           <= `SWS_LOW_MIN;
      curWrite         <= 1'b0;
      accBusy          <= 1'b0;
      accDone          <= 1'b0;
      chipSelectLine_n <= 4'hf;
      readStrobe_n     <= 1'b1;
      writeStrobe_n    <= 1'b1;
    end else if (clkEn) begin
      accDone <= 1'b0;
      case (state)
        sws_pkg::SWS_IDLE: begin
          if (accReq) begin
            selCtrl  <= (accCs == 2'b00) ? cs0Ctrl : cs123Ctrl;
            lowCnt   <= lowCount((accCs == 2'b00) ? cs0Ctrl : cs123Ctrl,
                                 accWrite);
            curWrite <= accWrite;
            accBusy  <= 1'b1;
            chipSelectLine_n         <= 4'hf;
            chipSelectLine_n[accCs]  <= 1'b0;
            readStrobe_n  <= accWrite;
            writeStrobe_n <= !accWrite;
            state    <= sws_pkg::SWS_STROBE;
          end
        end
        sws_pkg::SWS_STROBE: begin
          if (waitOn && edgeMode) begin
            if (pinRise) begin
              state <= sws_pkg::SWS_END;
            end
          end else if (lowCnt != 4'h1) begin
            lowCnt <= lowCnt - 4'h1;
          end else if (waitOn && stallSeen) begin
            state <= sws_pkg::SWS_HOLD;
          end else begin
            state <= sws_pkg::SWS_END;
          end
        end
        sws_pkg::SWS_HOLD: begin
          if (!stallSeen) begin
            state <= sws_pkg::SWS_END;
          end
        end
        sws_pkg::SWS_END: begin
          chipSelectLine_n <= 4'hf;
          readStrobe_n     <= 1'b1;
          writeStrobe_n    <= 1'b1;
          accBusy          <= 1'b0;
          accDone          <= 1'b1;
          state            <= sws_pkg::SWS_IDLE;
        end
        default: begin
          state <= sws_pkg::SWS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  a_stall_enable_bit: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && wbWrite && wbAdr == `SWS_OFF_CS0_CTRL && wbSel[0])
    |=> cs0Ctrl[`SWS_BIT_STALL_EN] == $past(wbDatI[`SWS_BIT_STALL_EN]))
    else $error("Stall enable bit not written.");

  a_sample_bit_hold: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (state == sws_pkg::SWS_HOLD) |-> selCtrl[`SWS_BIT_STALL_SAMPLE]
    && selCtrl[`SWS_BIT_STALL_EN])
    else $error("Hold entered without sample bit.");

  a_mode_bit_hold: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (state == sws_pkg::SWS_HOLD) |-> selCtrl[`SWS_BIT_STALL_MODE])
    else $error("Hold entered in edge mode.");

  a_cs_word_select: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_IDLE && accReq && accCs != 2'b00)
    |=> selCtrl == $past(cs123Ctrl) && chipSelectLine_n[$past(accCs)] == 1'b0)
    else $error("Wrong control word for select.");

  a_edge_ends_access: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_STROBE && waitOn && edgeMode && pinRise)
    |=> state == sws_pkg::SWS_END ##1 accDone)
    else $error("Edge did not end access.");

  a_count_before_look: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_STROBE && !(waitOn && edgeMode)
     && lowCnt != 4'h1)
    |=> state == sws_pkg::SWS_STROBE && lowCnt == $past(lowCnt) - 4'h1)
    else $error("Strobe count cut short.");

  a_hold_while_stall: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_HOLD && stallSeen)
    |=> state == sws_pkg::SWS_HOLD && (!readStrobe_n || !writeStrobe_n))
    else $error("Access released during stall.");

  a_no_stall_ends: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_STROBE && !edgeMode && lowCnt == 4'h1
     && !stallSeen)
    |=> state == sws_pkg::SWS_END)
    else $error("Access not ended at expiry.");

  a_fixed_timing: assert property (@(posedge core_clk)
    disable iff (!rstSync_n)
    (clkEn && state == sws_pkg::SWS_STROBE && !waitOn && lowCnt == 4'h1)
    |=> state == sws_pkg::SWS_END)
    else $error("Disabled stall stretched access.");

endmodule : sws_top
`default_nettype wire

// ==== tb/sws_sram_model.sv ====
// Behavioural memory that stretches accesses through the stall pin.
`timescale 1ns/10ps
`default_nettype none

module sws_sram_model (
  // Clock
  input  wire logic       core_clk,
  // Memory pins
  input  wire logic [3:0] chipSelectLine_n,
  input  wire logic [7:0] stallLen,
  output logic            stallPin_n
);
  // ==========================================================================
  // Stall generation
  logic [7:0] selCycles = 8'h00;
  logic       selected;

  assign selected = ~&chipSelectLine_n;

  always_ff @(posedge core_clk) begin
    if (!selected) begin
      selCycles <= 8'h00;
    end else if (selCycles != 8'hff) begin
      selCycles <= selCycles + 8'h01;
    end
  end

  // Stall is asserted from select for stallLen cycles, then negated.
  // The pin has a pull-up, so it reads high whenever nothing is selected.
  assign stallPin_n = !(selected && (selCycles < stallLen));

endmodule : sws_sram_model
`default_nettype wire

// ==== tb/sws_top_tb.sv ====
// Self-checking testbench of the stall-stretching access sequencer.
`timescale 1ns/10ps
`default_nettype none

module sws_top_tb;
  // ==========================================================================
  // Signals
  logic        core_clk, rstn, clkEn, wbCyc, wbStb, wbWe, wbAck;
  logic        accReq, accWrite, accBusy, accDone;
  logic        stallPin_n, readStrobe_n, writeStrobe_n;
  logic [1:0]  accCs;
  logic [3:0]  wbSel, chipSelectLine_n;
  logic [7:0]  wbAdr, stallLen;
  logic [31:0] wbDatI, wbDatO;
  int          err_total, check_count;
  localparam logic [31:0] FIX = 32'h0000_0a80;
  localparam logic [31:0] ENO = 32'h0000_0a84;
  localparam logic [31:0] TMO = 32'h0001_0a8c;
  localparam logic [31:0] EDG = 32'h0000_0a8c;

  sws_top i_dut (.core_clk, .rstn, .clkEn, .wbCyc, .wbStb, .wbWe,
    .wbAdr, .wbSel, .wbDatI, .wbDatO, .wbAck, .accReq, .accWrite, .accCs,
    .accBusy, .accDone, .stallPin_n, .chipSelectLine_n, .readStrobe_n,
    .writeStrobe_n);

  sws_sram_model i_mem (.core_clk, .chipSelectLine_n, .stallLen,
    .stallPin_n);

  // ==========================================================================
  // Reporting
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    err_total++;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  endtask : fail

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) fail(got, exp);
  endtask : chk

  // ==========================================================================
  // Wishbone classic single cycle
  task automatic wbXfer(input logic we, input logic [7:0] adr,
                        input logic [31:0] dat, output logic [31:0] rd);
    int i;
    @(posedge core_clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= dat;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wbAck !== 1'b1 && i < 50);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (i >= 50) begin
      fail(32'h0, 32'h1);
      stop_test();
    end
  endtask : wbXfer

  task automatic wbRd(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wbXfer(1'b0, adr, 32'h0, rd);
    chk(rd, exp);
  endtask : wbRd

  task automatic wbWr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wbXfer(1'b1, adr, dat, rd);
  endtask : wbWr

  // ==========================================================================
  // One access with given control words and stall length
  task automatic runCase(input logic [31:0] w0, input logic [31:0] w1,
                         input logic [1:0] cs, input logic wr,
                         input logic [7:0] len, input int lo, input int hi,
                         input int frz);
    int n;
    logic [3:0] csExp;
    wbWr(8'h00, w0);
    wbWr(8'h04, w1);
    wbRd(8'h00, w0);
    wbRd(8'h04, w1);
    csExp = ~(4'h1 << cs);
    @(posedge core_clk);
    accReq   <= 1'b1;
    accCs    <= cs;
    accWrite <= wr;
    stallLen <= len;
    @(posedge core_clk);
    accReq <= 1'b0;
    // Clock enable low freezes the accepted access for frz cycles.
    if (frz > 0) begin
      clkEn <= 1'b0;
      repeat (frz) @(posedge core_clk);
      clkEn <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (n == 1) begin
        chk({28'h0, chipSelectLine_n}, {28'h0, csExp});
        chk({30'h0, readStrobe_n, writeStrobe_n}, wr ? 32'h2 : 32'h1);
        chk({31'h0, accBusy}, 32'h1);
      end
    end while (accDone !== 1'b1 && n < 100);
    check_count++;
    if (n < lo || n > hi) fail(n, lo);
    chk({31'h0, accBusy}, 32'h0);
    if (n >= 100) stop_test();
  endtask : runCase

  // ==========================================================================
  // Clock and main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    rstn = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 8'h00;
    wbSel = 4'hf; wbDatI = 32'h0; accReq = 1'b0; accWrite = 1'b0;
    accCs = 2'h0; stallLen = 8'h00; err_total = 0; check_count = 0;
    clkEn = 1'b1;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    wbRd(8'h00, 32'h0);
    wbRd(8'h04, 32'h0);
    wbRd(8'h08, 32'h0);
    wbWr(8'h0c, 32'hffff_ffff);
    wbRd(8'h0c, 32'h0);
    // Edge-mode cases always stall, as that mode requires.
    runCase(FIX, FIX, 2'h0, 1'b0, 8'h0e, 9, 9, 0);
    runCase(ENO, FIX, 2'h0, 1'b1, 8'h0e, 11, 11, 0);
    runCase(TMO, FIX, 2'h0, 1'b0, 8'h00, 9, 9, 0);
    runCase(TMO, FIX, 2'h0, 1'b0, 8'h02, 9, 9, 0);
    runCase(TMO, FIX, 2'h0, 1'b0, 8'h0e, 15, 26, 0);
    runCase(FIX, TMO, 2'h2, 1'b1, 8'h10, 17, 28, 0);
    runCase(TMO, FIX, 2'h1, 1'b0, 8'h0e, 9, 9, 3);
    runCase(EDG, FIX, 2'h0, 1'b0, 8'h0e, 15, 26, 0);
    runCase(FIX, EDG, 2'h3, 1'b1, 8'h14, 21, 32, 0);
    // A second reset in mid-run clears both control words again.
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    wbRd(8'h00, 32'h0);
    wbRd(8'h04, 32'h0);
    stop_test();
  end

endmodule : sws_top_tb
`default_nettype wire
